/* hw/rii_pkg.sv */
// Constants shared by the row input interconnect design
`default_nettype none
package rii_pkg;
   // Array shape
   localparam int ROWS   = 2;
   localparam int LANES  = 4;
   localparam int BLOCKS = ROWS * LANES;
   localparam int SEL_W  = 2;

   // Register offsets, identical in both banks
   localparam logic [7:0] ROW0_SELECT_OFFSET = 8'hb0;
   localparam logic [7:0] ROW0_BYPASS_OFFSET = 8'hb1;
   localparam logic [7:0] ROW1_SELECT_OFFSET = 8'hb8;
   localparam logic [7:0] ROW1_BYPASS_OFFSET = 8'h89;

   // Reset values and implemented-bit masks
   localparam logic [7:0] SELECT_RESET  = 8'h00;
   localparam logic [3:0] BYPASS_RESET  = 4'h0;
   localparam logic [7:0] BYPASS_MASK   = 8'h0f;
   localparam logic [7:0] READ_IDLE     = 8'h00;
   localparam logic       KEEPER_RESET  = 1'b1;

   // Lane mux select codes
   localparam logic [1:0] SEL_EVEN_LOW  = 2'h0;
   localparam logic [1:0] SEL_EVEN_HIGH = 2'h1;
   localparam logic [1:0] SEL_ODD_LOW   = 2'h2;
   localparam logic [1:0] SEL_ODD_HIGH  = 2'h3;
   localparam int         HIGH_HALF     = 4;

   // Block kinds within a row: basic, basic, comm, comm
   localparam logic [LANES-1:0] ROW_COMM_MASK = 4'hc;
endpackage
`default_nettype wire

/* hw/rii_lane_sync.sv */
// One row input lane: two-flop synchronizer with a bypass
`default_nettype none
module rii_lane_sync (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic resetn_in,
   // Lane
   input  wire logic lane_raw_in,
   input  wire logic bypass_in,
   output logic      lane_out
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } rii_sync_s;

   rii_sync_s st;
   rii_sync_s next_st;

   // Shift the raw lane through two stages
   always_comb begin
      next_st        = st;
      next_st.stage1 = lane_raw_in;
      next_st.stage2 = st.stage1;
   end

   // State register
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Bypass passes the lane straight through
   assign lane_out = bypass_in ? lane_raw_in : st.stage2;

   // Synchronized lane lags the raw lane by two cycles
   sync_delay_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!bypass_in && $past(!bypass_in) && $past(resetn_in, 2) && $past(resetn_in, 3))
      |-> (lane_out == $past(lane_raw_in, 2)))
      else $error("synchronized lane not two cycles behind input");

   // Bypassed lane equals the raw lane
   bypass_pass_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      bypass_in |-> (lane_out == lane_raw_in))
      else $error("bypassed lane differs from input");
endmodule
`default_nettype wire

/* hw/rii_row_array.sv */
// Two-row array: input lane routing, sync, keepers, chaining, priority
//
// Chosen here: the plain strobed port.
`default_nettype none
module rii_row_array (
   // Clock and reset
   input  wire logic                       clock_in,
   input  wire logic                       resetn_in,
   // Register port
   input  wire logic [7:0]                 addr_in,
   input  wire logic [7:0]                 wdata_in,
   input  wire logic                       wr_in,
   input  wire logic                       rd_in,
   output logic      [7:0]                 rdata_out,
   // Global input buses
   input  wire logic [7:0]                 global_in_even_in,
   input  wire logic [7:0]                 global_in_odd_in,
   // Row input lanes to blocks, row-major
   output logic      [rii_pkg::BLOCKS-1:0] lane_input_out,
   // Row outputs from blocks, with keepers
   input  wire logic [rii_pkg::BLOCKS-1:0] block_out_in,
   input  wire logic [rii_pkg::BLOCKS-1:0] block_out_en_in,
   output logic      [rii_pkg::BLOCKS-1:0] lane_output_out,
   // Broadcast nets
   input  wire logic [rii_pkg::BLOCKS-1:0] block_bc_in,
   input  wire logic [rii_pkg::BLOCKS-1:0] block_bc_en_in,
   input  wire logic [rii_pkg::ROWS-1:0]   bc_ext_en_in,
   output logic      [rii_pkg::ROWS-1:0]   broadcast_net_out,
   // Block chain
   input  wire logic [rii_pkg::BLOCKS-1:0] chain_fwd_in,
   input  wire logic [rii_pkg::BLOCKS-1:0] chain_bwd_in,
   output logic      [rii_pkg::BLOCKS-1:0] chain_prev_out,
   output logic      [rii_pkg::BLOCKS-1:0] chain_next_out,
   // Interrupt ordering and block kinds
   input  wire logic [rii_pkg::BLOCKS-1:0] block_irq_in,
   output logic                            irq_valid_out,
   output logic      [2:0]                 irq_vector_out,
   output logic      [rii_pkg::BLOCKS-1:0] block_is_comm_out
);
   typedef struct packed {
      logic [rii_pkg::ROWS-1:0][7:0]              sel;
      logic [rii_pkg::ROWS-1:0][rii_pkg::LANES-1:0] byp;
      logic [rii_pkg::ROWS-1:0]                   bc;
      logic [rii_pkg::BLOCKS-1:0]                 ro;
      logic                                       irq_valid;
      logic [2:0]                                 irq_vec;
      logic [7:0]                                 rdata;
   } rii_state_s;

   localparam rii_state_s RESET_STATE = '{
      sel:       {rii_pkg::ROWS{rii_pkg::SELECT_RESET}},
      byp:       {rii_pkg::ROWS{rii_pkg::BYPASS_RESET}},
      bc:        {rii_pkg::ROWS{rii_pkg::KEEPER_RESET}},
      ro:        {rii_pkg::BLOCKS{rii_pkg::KEEPER_RESET}},
      irq_valid: 1'b0,
      irq_vec:   3'h0,
      rdata:     rii_pkg::READ_IDLE
   };

   rii_state_s                st;
   rii_state_s                next_st;
   logic [rii_pkg::BLOCKS-1:0] lane_raw;

   // Select register offset of a row
   function automatic logic [7:0] select_offset(input int row);
      return (row == 0) ? rii_pkg::ROW0_SELECT_OFFSET : rii_pkg::ROW1_SELECT_OFFSET;
   endfunction

   // Bypass register offset of a row
   function automatic logic [7:0] bypass_offset(input int row);
      return (row == 0) ? rii_pkg::ROW0_BYPASS_OFFSET : rii_pkg::ROW1_BYPASS_OFFSET;
   endfunction

   // Four-way lane mux over the global input buses
   function automatic logic route_lane(input logic [1:0] sel,
                                       input logic [7:0] even,
                                       input logic [7:0] odd,
                                       input int         lane);
      logic r;
      r = 1'b0;
      unique case (sel)
         rii_pkg::SEL_EVEN_LOW:  r = even[lane];
         rii_pkg::SEL_EVEN_HIGH: r = even[lane + rii_pkg::HIGH_HALF];
         rii_pkg::SEL_ODD_LOW:   r = odd[lane];
         rii_pkg::SEL_ODD_HIGH:  r = odd[lane + rii_pkg::HIGH_HALF];
      endcase
      return r;
   endfunction

   // Identical routing and sync for every row and lane
   for (genvar r = 0; r < rii_pkg::ROWS; r++) begin : g_row
      for (genvar n = 0; n < rii_pkg::LANES; n++) begin : g_lane
         assign lane_raw[r*rii_pkg::LANES+n] = route_lane(
            st.sel[r][n*rii_pkg::SEL_W +: rii_pkg::SEL_W],
            global_in_even_in, global_in_odd_in, n);
         rii_lane_sync u_sync (
            .clock_in    (clock_in),
            .resetn_in   (resetn_in),
            .lane_raw_in (lane_raw[r*rii_pkg::LANES+n]),
            .bypass_in   (st.byp[r][n]),
            .lane_out    (lane_input_out[r*rii_pkg::LANES+n])
         );
      end
   end

   // Block chain as one string with grounded ends
   for (genvar k = 0; k < rii_pkg::BLOCKS; k++) begin : g_chain
      if (k == 0) begin : g_first
         assign chain_prev_out[k] = 1'b0;
      end else begin : g_prev
         assign chain_prev_out[k] = chain_fwd_in[k-1];
      end
      if (k == rii_pkg::BLOCKS - 1) begin : g_last
         assign chain_next_out[k] = 1'b0;
      end else begin : g_next
         assign chain_next_out[k] = chain_bwd_in[k+1];
      end
      assign block_is_comm_out[k] = rii_pkg::ROW_COMM_MASK[k % rii_pkg::LANES];
   end

   // Next state: registers, keepers, broadcast, priority
   always_comb begin
      logic bc_driven;
      logic bc_value;
      next_st       = st;
      bc_driven     = 1'b0;
      bc_value      = 1'b0;
      next_st.rdata = rii_pkg::READ_IDLE;
      // Decode ignores the bank, so both banks alias
      for (int r = 0; r < rii_pkg::ROWS; r++) begin
         if (wr_in && addr_in == select_offset(r)) begin
            next_st.sel[r] = wdata_in;
         end
         if (wr_in && addr_in == bypass_offset(r)) begin
            next_st.byp[r] = wdata_in[rii_pkg::LANES-1:0];
         end
         if (rd_in && addr_in == select_offset(r)) begin
            next_st.rdata = st.sel[r];
         end
         if (rd_in && addr_in == bypass_offset(r)) begin
            next_st.rdata = {4'h0, st.byp[r]} & rii_pkg::BYPASS_MASK;
         end
      end
      // Row output keepers
      for (int b = 0; b < rii_pkg::BLOCKS; b++) begin
         if (block_out_en_in[b]) begin
            next_st.ro[b] = block_out_in[b];
         end
      end
      // Broadcast keepers: own block first, else other row
      for (int r = 0; r < rii_pkg::ROWS; r++) begin
         bc_driven = 1'b0;
         bc_value  = 1'b0;
         for (int n = rii_pkg::LANES - 1; n >= 0; n--) begin
            if (block_bc_en_in[r*rii_pkg::LANES+n]) begin
               bc_driven = 1'b1;
               bc_value  = block_bc_in[r*rii_pkg::LANES+n];
            end
         end
         if (bc_driven) begin
            next_st.bc[r] = bc_value;
         end else if (bc_ext_en_in[r]) begin
            next_st.bc[r] = st.bc[(r + 1) % rii_pkg::ROWS];
         end
      end
      // Lowest-numbered requesting block wins
      next_st.irq_valid = |block_irq_in;
      next_st.irq_vec   = 3'h0;
      for (int b = rii_pkg::BLOCKS - 1; b >= 0; b--) begin
         if (block_irq_in[b]) begin
            next_st.irq_vec = 3'(b);
         end
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= RESET_STATE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs from state
   assign rdata_out         = st.rdata;
   assign lane_output_out   = st.ro;
   assign broadcast_net_out = st.bc;
   assign irq_valid_out     = st.irq_valid;
   assign irq_vector_out    = st.irq_vec;

   // Select write lands next cycle
   sel_write_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (wr_in && addr_in == rii_pkg::ROW0_SELECT_OFFSET)
      |=> (st.sel[0] == $past(wdata_in)))
      else $error("row0 select write not stored");

   // Odd high-half routing of lane 0
   route_lane_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (st.sel[0][1:0] == rii_pkg::SEL_ODD_HIGH)
      |-> (lane_raw[0] == global_in_odd_in[rii_pkg::HIGH_HALF]))
      else $error("lane 0 not routed from odd high input");

   // Bypass readback of row 1
   bypass_read_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (rd_in && addr_in == rii_pkg::ROW1_BYPASS_OFFSET)
      |=> (rdata_out == {4'h0, $past(st.byp[1])}))
      else $error("row1 bypass readback wrong");

   // Keeper holds an undriven row output
   keeper_hold_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      !block_out_en_in[0] |=> $stable(lane_output_out[0]))
      else $error("undriven row output changed");

   // Keeper follows a driven row output
   keeper_load_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      block_out_en_in[3] |=> (lane_output_out[3] == $past(block_out_in[3])))
      else $error("driven row output not captured");

   // Row 0 broadcast taken from row 1 when undriven
   bc_external_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!(|block_bc_en_in[rii_pkg::LANES-1:0]) && bc_ext_en_in[0])
      |=> (broadcast_net_out[0] == $past(broadcast_net_out[1])))
      else $error("row0 broadcast not taken from row1");

   // Block 0 always wins priority
   irq_order_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      block_irq_in[0] |=> (irq_valid_out && irq_vector_out == 3'h0))
      else $error("block 0 interrupt not first");

   // Chain ends grounded and rows linked
   chain_link_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (chain_prev_out[0] == 1'b0) && (chain_next_out[rii_pkg::BLOCKS-1] == 1'b0)
      && (chain_prev_out[rii_pkg::LANES] == chain_fwd_in[rii_pkg::LANES-1]))
      else $error("chain ends or row link wrong");
endmodule
`default_nettype wire

/* tb/rii_far_model.sv */
// Far side model: global input buses and the digital blocks of both rows
`default_nettype none
module rii_far_model (
   // Clock
   input  wire logic       clock_in,
   // Globals and block outputs
   output logic [7:0] global_in_even_out,
   output logic [7:0] global_in_odd_out,
   output logic [7:0] block_out_out,
   output logic [7:0] block_out_en_out,
   output logic [7:0] block_bc_out,
   output logic [7:0] block_bc_en_out,
   output logic [1:0] bc_ext_en_out,
   output logic [7:0] chain_fwd_out,
   output logic [7:0] chain_bwd_out,
   output logic [7:0] block_irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] out_v;
   logic [7:0] bc_v;
   // Released drivers show the inverse, never a stale value
   assign block_out_out = (out_v & block_out_en_out) | (~out_v & ~block_out_en_out);
   assign block_bc_out  = (bc_v & block_bc_en_out) | (~bc_v & ~block_bc_en_out);
   initial begin
      {global_in_even_out, global_in_odd_out, out_v, block_out_en_out} = '0;
      {bc_v, block_bc_en_out, bc_ext_en_out, chain_fwd_out, chain_bwd_out} = '0;
      block_irq_out = '0;
   end
   // Every change lands just after a rising edge
   task automatic set_globals(input logic [7:0] e, input logic [7:0] o);
      global_in_even_out <= e;
      global_in_odd_out  <= o;
   endtask
   task automatic set_blocks(input logic [7:0] v, input logic [7:0] en,
                             input logic [7:0] bv, input logic [7:0] ben, input logic [1:0] x);
      out_v            <= v;
      block_out_en_out <= en;
      bc_v             <= bv;
      block_bc_en_out  <= ben;
      bc_ext_en_out    <= x;
   endtask
   task automatic set_misc(input logic [7:0] f, input logic [7:0] b, input logic [7:0] q);
      chain_fwd_out <= f;
      chain_bwd_out <= b;
      block_irq_out <= q;
   endtask
endmodule
`default_nettype wire

/* tb/row_input_interconnect_tb.sv */
// Self-checking bench for the two-row input interconnect
`default_nettype none
module row_input_interconnect_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in, resetn_in, wr_in, rd_in;
   logic [7:0] addr_in, wdata_in, rdata_out, ge, go, bo, boe, bb, bbe, cf, cb, irq;
   logic [7:0] lane_in, lane_o, prev_o, next_o, comm_o;
   logic [1:0] bc_x, bc_o;
   logic       irq_v;
   logic [2:0] irq_vec;
   logic [3:0] nib;
   int         fails, tests_run;
   rii_far_model far (.clock_in(clock_in), .global_in_even_out(ge), .global_in_odd_out(go),
      .block_out_out(bo), .block_out_en_out(boe), .block_bc_out(bb), .block_bc_en_out(bbe),
      .bc_ext_en_out(bc_x), .chain_fwd_out(cf), .chain_bwd_out(cb), .block_irq_out(irq));
   rii_row_array dut (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .global_in_even_in(ge), .global_in_odd_in(go), .lane_input_out(lane_in),
      .block_out_in(bo), .block_out_en_in(boe), .lane_output_out(lane_o),
      .block_bc_in(bb), .block_bc_en_in(bbe), .bc_ext_en_in(bc_x), .broadcast_net_out(bc_o),
      .chain_fwd_in(cf), .chain_bwd_in(cb), .chain_prev_out(prev_o), .chain_next_out(next_o),
      .block_irq_in(irq), .irq_valid_out(irq_v), .irq_vector_out(irq_vec),
      .block_is_comm_out(comm_o));
   // 10 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clock_in);
      wr_in    <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clock_in);
      rd_in   <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask
   task automatic edge_n(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #2ms;
      fails++;
      complete_run();
   end
   initial begin
      {wr_in, rd_in, addr_in, wdata_in, fails, tests_run} = '0;
      resetn_in = 1'b0;
      edge_n(2);
      resetn_in = 1'b1;
      // Reset values, keepers, block kinds
      rd(8'hb0, 8'h00);
      rd(8'hb1, 8'h00);
      rd(8'hb8, 8'h00);
      rd(8'h89, 8'h00);
      rd(8'hb2, 8'h00);
      chk(lane_o, 8'hff);
      chk({6'h0, bc_o}, 8'h03);
      chk(comm_o, 8'hcc);
      $display("Test reset done");
      // Every mux code on all lanes of both rows, sync bypassed
      wr(8'hb1, 8'h0f);
      wr(8'h89, 8'h0f);
      rd(8'h89, 8'h0f);
      far.set_globals(8'h9c, 8'h63);
      for (int c = 0; c < 4; c++) begin
         wr(8'hb0, {4{c[1:0]}});
         wr(8'hb8, {4{c[1:0]}});
         rd(8'hb0, {4{c[1:0]}});
         nib = c[1] ? (c[0] ? go[7:4] : go[3:0]) : (c[0] ? ge[7:4] : ge[3:0]);
         chk(lane_in, {nib, nib});
      end
      $display("Test lane mux done");
      // Per-lane bypass against two-flop sync
      wr(8'hb0, 8'h00);
      wr(8'hb8, 8'h00);
      wr(8'hb1, 8'h01);
      wr(8'h89, 8'h08);
      far.set_globals(8'h00, 8'h00);
      edge_n(3);
      far.set_globals(8'hff, 8'h00);
      #1;
      chk(lane_in, 8'h81);
      edge_n(1);
      chk(lane_in, 8'h81);
      edge_n(1);
      chk(lane_in, 8'hff);
      $display("Test sync done");
      // Chain ends, interrupt order, keepers and broadcast
      far.set_misc(8'h5b, 8'hb5, 8'h30);
      far.set_blocks(8'h00, 8'h01, 8'h00, 8'h02, 2'b10);
      edge_n(1);
      chk(prev_o, 8'hb6);
      chk(next_o, 8'h5a);
      edge_n(1);
      chk({7'h0, irq_v}, 8'h01);
      chk({5'h0, irq_vec}, 8'h04);
      chk(lane_o, 8'hfe);
      edge_n(1);
      chk({6'h0, bc_o}, 8'h00);
      far.set_blocks(8'h00, 8'h00, 8'h00, 8'h00, 2'b10);
      edge_n(3);
      chk(lane_o, 8'hfe);
      chk({6'h0, bc_o}, 8'h00);
      $display("Test array wiring done");
      complete_run();
   end
endmodule
`default_nettype wire
